// ==== rtl/dect_top.sv ====
/*
  Dual event counter timer: two counters with selectable count, start and
  clear sources, start and end events, capture on clear, status and a masked
  interrupt. Assumes one 100 MHz clock, a synchronous active-high reset, a
  strobe register port, asynchronous line pins and same-clock internal events.
*/
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dect_top
  import dect_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire dect_bus_t bus,
  output logic [DATA_W-1:0] rdata,
  input wire logic [NUM_LINE-1:0] line_in,
  input wire logic [3:0] user_out,
  input wire logic [1:0] logic_blk,
  input wire logic exposure_start,
  input wire logic exposure_end,
  input wire logic frame_trigger_wait,
  output logic [NUM_CNT-1:0] counter_start_evt,
  output logic [NUM_CNT-1:0] counter_end_evt,
  output logic irq
);
  typedef struct packed {
    logic sel;
    dect_cfg_t [NUM_CNT-1:0] cfg;
    dect_cnt_t [NUM_CNT-1:0] cnt;
    logic [NUM_CNT-1:0] start_evt;
    logic [NUM_CNT-1:0] end_evt;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [DATA_W-1:0] rdata;
    logic [NUM_LINE-1:0] line_meta;
    logic [NUM_LINE-1:0] line_sync;
  } dect_top_t;

  dect_top_t s;
  dect_top_t next_s;

  logic microsecond_tick;
  logic [SRC_COUNT-1:0] src_vec;
  logic [NUM_CNT-1:0] count_hit;
  logic [NUM_CNT-1:0] trig_hit;
  logic [NUM_CNT-1:0] clear_hit;

  dect_tick u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(microsecond_tick)
  );

  // Counter events feed back one cycle late, so a counter may chain on
  // itself or its sibling without a combinational loop.
  assign src_vec = {frame_trigger_wait,
                    exposure_end,
                    exposure_start,
                    logic_blk,
                    s.end_evt,
                    s.start_evt,
                    user_out,
                    s.line_sync,
                    microsecond_tick,
                    1'b0};

  for (genvar g = 0; g < NUM_CNT; g++) begin : g_qual
    dect_qual u_count (
      .ref_clk(ref_clk),
      .rst(rst),
      .src_vec(src_vec),
      .sel(s.cfg[g].count_source_select),
      .mode(s.cfg[g].count_activation_mode),
      .hit(count_hit[g])
    );
    dect_qual u_trig (
      .ref_clk(ref_clk),
      .rst(rst),
      .src_vec(src_vec),
      .sel(s.cfg[g].start_trigger_select),
      .mode(s.cfg[g].start_trigger_activation_mode),
      .hit(trig_hit[g])
    );
    dect_qual u_clear (
      .ref_clk(ref_clk),
      .rst(rst),
      .src_vec(src_vec),
      .sel(s.cfg[g].clear_source_select),
      .mode(s.cfg[g].clear_activation_mode),
      .hit(clear_hit[g])
    );
  end

  always_comb begin
    logic [CNT_W-1:0] inc;
    logic [IRQ_W-1:0] new_ev;
    logic [2:0] code;
    logic src_on;
    logic trig_on;
    logic wr_src_on;
    inc = '0;
    src_on = 1'b0;
    trig_on = 1'b0;
    wr_src_on = 1'b0;
    new_ev = '0;
    code = STAT_IDLE;
    next_s = s;
    // Line pins pass two flops before any qualifier sees them.
    next_s.line_meta = line_in;
    next_s.line_sync = s.line_meta;
    next_s.start_evt = '0;
    next_s.end_evt = '0;
    next_s.rdata = '0;
    // Codes past the last source select nothing and behave exactly like off.
    wr_src_on = (bus.wdata[SRC_W-1:0] != SRC_OFF) &&
                (bus.wdata[SRC_W-1:0] < SRC_COUNT[SRC_W-1:0]);

    if (bus.wr) begin
      case (bus.addr)
        REG_INDEX: begin
          next_s.sel = bus.wdata[0];
        end
        REG_COUNT_SRC: begin
          next_s.cfg[s.sel].count_source_select = bus.wdata[SRC_W-1:0];
        end
        REG_COUNT_ACT: begin
          next_s.cfg[s.sel].count_activation_mode = bus.wdata[ACT_W-1:0];
        end
        REG_START_DELAY: begin
          next_s.cfg[s.sel].start_delay_count = bus.wdata;
        end
        REG_END_DURATION: begin
          next_s.cfg[s.sel].end_duration_count = bus.wdata;
        end
        REG_TRIG_SRC: begin
          next_s.cfg[s.sel].start_trigger_select = bus.wdata[SRC_W-1:0];
          if (wr_src_on) begin
            next_s.cfg[s.sel].clear_source_select = SRC_OFF;
          end
        end
        REG_TRIG_ACT: begin
          next_s.cfg[s.sel].start_trigger_activation_mode = bus.wdata[ACT_W-1:0];
        end
        REG_CLEAR_SRC: begin
          next_s.cfg[s.sel].clear_source_select = bus.wdata[SRC_W-1:0];
          if (wr_src_on) begin
            next_s.cfg[s.sel].start_trigger_select = SRC_OFF;
          end
        end
        REG_CLEAR_ACT: begin
          next_s.cfg[s.sel].clear_activation_mode = bus.wdata[ACT_W-1:0];
        end
        REG_CAPTURED: begin
          // Software may preset the captured value; the next clear outside idle overwrites it.
          next_s.cnt[s.sel].count_captured_on_clear = bus.wdata;
        end
        REG_IRQ_MASK: begin
          next_s.irq_mask = bus.wdata[IRQ_W-1:0];
        end
        REG_PRESENT_COUNT, REG_STATE_REPORT, REG_IRQ_STATUS: begin
          // Read-only: a write here is dropped and does not clear any status.
        end
        default: begin
        end
      endcase
    end

    for (int i = 0; i < NUM_CNT; i++) begin
      inc = s.cnt[i].present_count + 32'h0000_0001;
      // The state machine and the qualifiers must agree on what counts as off.
      src_on = (s.cfg[i].count_source_select != SRC_OFF) &&
               (s.cfg[i].count_source_select < SRC_COUNT[SRC_W-1:0]);
      trig_on = (s.cfg[i].start_trigger_select != SRC_OFF) &&
                (s.cfg[i].start_trigger_select < SRC_COUNT[SRC_W-1:0]);
      if (!src_on) begin
        // With no count source the counter parks and keeps its value.
        next_s.cnt[i].state = ST_IDLE;
      end else begin
        case (s.cnt[i].state)
          ST_IDLE: begin
            // Leaving idle always starts from zero, so a stale count never leaks.
            next_s.cnt[i].present_count = '0;
            if (trig_on) begin
              next_s.cnt[i].state = ST_WAIT;
            end else begin
              next_s.cnt[i].state = ST_ACTIVE;
            end
          end
          ST_WAIT, ST_DONE, ST_OVFL: begin
            // A trigger restarts a finished or overflowed counter from zero.
            if (trig_hit[i]) begin
              next_s.cnt[i].present_count = '0;
              next_s.cnt[i].state = ST_ACTIVE;
            end else if (s.cnt[i].state == ST_WAIT && !trig_on) begin
              next_s.cnt[i].state = ST_ACTIVE;
            end
          end
          ST_ACTIVE: begin
            if (count_hit[i]) begin
              // Parking at the top keeps a wrap from firing the events again.
              if (s.cnt[i].present_count == '1) begin
                next_s.cnt[i].state = ST_OVFL;
              end else begin
                next_s.cnt[i].present_count = inc;
                if (s.cfg[i].start_delay_count != '0 &&
                    inc == s.cfg[i].start_delay_count) begin
                  next_s.start_evt[i] = 1'b1;
                end
                if (s.cfg[i].end_duration_count != '0 &&
                    inc == s.cfg[i].end_duration_count) begin
                  next_s.end_evt[i] = 1'b1;
                  next_s.cnt[i].state = ST_DONE;
                end
              end
            end
          end
          default: begin
            next_s.cnt[i].state = ST_IDLE;
          end
        endcase
        // A clear overrides counting in the same cycle and restarts the count.
        // An idle counter has nothing to end, so it keeps its captured value.
        if (clear_hit[i] && s.cnt[i].state != ST_IDLE) begin
          next_s.cnt[i].count_captured_on_clear = s.cnt[i].present_count;
          next_s.cnt[i].present_count = '0;
          next_s.cnt[i].state = ST_ACTIVE;
          next_s.start_evt[i] = 1'b0;
          next_s.end_evt[i] = 1'b0;
        end
      end
    end

    case (s.cnt[s.sel].state)
      ST_IDLE: code = STAT_IDLE;
      ST_WAIT: code = STAT_TRIG_WAIT;
      ST_ACTIVE: code = STAT_ACTIVE;
      ST_DONE: code = STAT_COMPLETED;
      ST_OVFL: code = STAT_OVERFLOW;
      default: code = STAT_IDLE;
    endcase

    if (bus.rd) begin
      case (bus.addr)
        REG_INDEX: begin
          next_s.rdata = {31'h0000_0000, s.sel};
        end
        REG_COUNT_SRC: begin
          next_s.rdata = {27'h000_0000, s.cfg[s.sel].count_source_select};
        end
        REG_COUNT_ACT: begin
          next_s.rdata = {29'h000_0000, s.cfg[s.sel].count_activation_mode};
        end
        REG_START_DELAY: begin
          next_s.rdata = s.cfg[s.sel].start_delay_count;
        end
        REG_END_DURATION: begin
          next_s.rdata = s.cfg[s.sel].end_duration_count;
        end
        REG_TRIG_SRC: begin
          next_s.rdata = {27'h000_0000, s.cfg[s.sel].start_trigger_select};
        end
        REG_TRIG_ACT: begin
          next_s.rdata = {29'h000_0000, s.cfg[s.sel].start_trigger_activation_mode};
        end
        REG_CLEAR_SRC: begin
          next_s.rdata = {27'h000_0000, s.cfg[s.sel].clear_source_select};
        end
        REG_CLEAR_ACT: begin
          next_s.rdata = {29'h000_0000, s.cfg[s.sel].clear_activation_mode};
        end
        REG_PRESENT_COUNT: begin
          next_s.rdata = s.cnt[s.sel].present_count;
        end
        REG_CAPTURED: begin
          next_s.rdata = s.cnt[s.sel].count_captured_on_clear;
        end
        REG_STATE_REPORT: begin
          next_s.rdata = {29'h000_0000, code};
        end
        REG_IRQ_STATUS: begin
          next_s.rdata = {28'h000_0000, s.irq_status};
        end
        REG_IRQ_MASK: begin
          next_s.rdata = {28'h000_0000, s.irq_mask};
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end

    // Read clears the sticky bits, but an event in that cycle still lands.
    // Status bit 2i is the start event of counter i and bit 2i+1 its end event.
    for (int i = 0; i < NUM_CNT; i++) begin
      new_ev[2 * i] = next_s.start_evt[i];
      new_ev[2 * i + 1] = next_s.end_evt[i];
    end
    if (bus.rd && bus.addr == REG_IRQ_STATUS) begin
      next_s.irq_status = new_ev;
    end else begin
      next_s.irq_status = s.irq_status | new_ev;
    end
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.cfg <= {NUM_CNT{CFG_RESET}};
      // All zeros is not a legal state code, so each state gets its idle code.
      for (int i = 0; i < NUM_CNT; i++) begin
        s.cnt[i].state <= ST_IDLE;
      end
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign counter_start_evt = s.start_evt;
  assign counter_end_evt = s.end_evt;
  assign irq = s.irq;
endmodule : dect_top
`default_nettype wire

// ==== rtl/dect_pkg.sv ====
/*
  Shared constants and types of the dual event counter timer: register offsets,
  source and activation codes, status codes, reset values and timing counts.
  Assumes a single 100 MHz clock and a plain strobe register port.
*/
package dect_pkg;
  localparam int CNT_W = 32;
  localparam int NUM_CNT = 2;
  localparam int SRC_W = 5;
  localparam int ACT_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 4;
  localparam int NUM_LINE = 4;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [ADDR_W-1:0] REG_INDEX = 8'h00;
  localparam logic [ADDR_W-1:0] REG_COUNT_SRC = 8'h04;
  localparam logic [ADDR_W-1:0] REG_COUNT_ACT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_START_DELAY = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_END_DURATION = 8'h10;
  localparam logic [ADDR_W-1:0] REG_TRIG_SRC = 8'h14;
  localparam logic [ADDR_W-1:0] REG_TRIG_ACT = 8'h18;
  localparam logic [ADDR_W-1:0] REG_CLEAR_SRC = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_CLEAR_ACT = 8'h20;
  localparam logic [ADDR_W-1:0] REG_PRESENT_COUNT = 8'h24;
  localparam logic [ADDR_W-1:0] REG_CAPTURED = 8'h28;
  localparam logic [ADDR_W-1:0] REG_STATE_REPORT = 8'h2C;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h34;

  // Source codes; bit positions of the source vector use the same numbers.
  localparam logic [SRC_W-1:0] SRC_OFF = 5'h00;
  localparam logic [SRC_W-1:0] SRC_TICK = 5'h01;
  localparam logic [SRC_W-1:0] SRC_LINE0 = 5'h02;
  localparam logic [SRC_W-1:0] SRC_USER0 = 5'h06;
  localparam logic [SRC_W-1:0] SRC_C0_START = 5'h0A;
  localparam logic [SRC_W-1:0] SRC_C0_END = 5'h0C;
  localparam logic [SRC_W-1:0] SRC_LOGIC0 = 5'h0E;
  localparam logic [SRC_W-1:0] SRC_EXP_START = 5'h10;
  localparam logic [SRC_W-1:0] SRC_EXP_END = 5'h11;
  localparam logic [SRC_W-1:0] SRC_FRAME_WAIT = 5'h12;
  localparam int SRC_COUNT = 19;

  localparam logic [ACT_W-1:0] ACT_LEVEL_LOW = 3'h0;
  localparam logic [ACT_W-1:0] ACT_LEVEL_HIGH = 3'h1;
  localparam logic [ACT_W-1:0] ACT_FALL = 3'h2;
  localparam logic [ACT_W-1:0] ACT_RISE = 3'h3;
  localparam logic [ACT_W-1:0] ACT_ANY = 3'h4;

  localparam logic [2:0] STAT_IDLE = 3'h0;
  localparam logic [2:0] STAT_TRIG_WAIT = 3'h1;
  localparam logic [2:0] STAT_ACTIVE = 3'h2;
  localparam logic [2:0] STAT_COMPLETED = 3'h3;
  localparam logic [2:0] STAT_OVERFLOW = 3'h4;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_ACTIVE = 5'b00100,
    ST_DONE = 5'b01000,
    ST_OVFL = 5'b10000
  } dect_state_t;

  typedef struct packed {
    logic [SRC_W-1:0] count_source_select;
    logic [ACT_W-1:0] count_activation_mode;
    logic [SRC_W-1:0] start_trigger_select;
    logic [ACT_W-1:0] start_trigger_activation_mode;
    logic [SRC_W-1:0] clear_source_select;
    logic [ACT_W-1:0] clear_activation_mode;
    logic [CNT_W-1:0] start_delay_count;
    logic [CNT_W-1:0] end_duration_count;
  } dect_cfg_t;

  localparam dect_cfg_t CFG_RESET = '{SRC_OFF, ACT_RISE, SRC_OFF, ACT_RISE,
                                      SRC_OFF, ACT_RISE, 32'h0000_0000, 32'h0000_0000};

  typedef struct packed {
    dect_state_t state;
    logic [CNT_W-1:0] present_count;
    logic [CNT_W-1:0] count_captured_on_clear;
  } dect_cnt_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dect_bus_t;
endpackage : dect_pkg

// ==== rtl/dect_tick.sv ====
/*
  Microsecond tick generator: one single-cycle pulse every DIV clock cycles.
  Assumes the clock and synchronous reset of the counter block.
*/
`timescale 1ns/1ps
`default_nettype none
module dect_tick
  import dect_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic tick
);
  typedef struct packed {
    logic [15:0] div_count;
    logic tick;
  } dect_tick_t;

  dect_tick_t s;
  dect_tick_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.div_count == 16'(DIV - 1)) begin
      next_s.div_count = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.div_count = s.div_count + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule : dect_tick
`default_nettype wire

// ==== rtl/dect_qual.sv ====
/*
  Activation qualifier: picks one bit of the source vector and turns it into
  count, trigger or clear hits by level or edge mode. Assumes sources already on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dect_qual
  import dect_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [SRC_COUNT-1:0] src_vec,
  input wire logic [SRC_W-1:0] sel,
  input wire logic [ACT_W-1:0] mode,
  output logic hit
);
  typedef struct packed {
    logic prev;
  } dect_qual_t;

  dect_qual_t s;
  dect_qual_t next_s;
  logic on;
  logic level;

  always_comb begin
    on = (sel != SRC_OFF) && (sel < SRC_COUNT[SRC_W-1:0]);
    level = on ? src_vec[sel] : 1'b0;
    next_s.prev = level;
    // Level modes hit every cycle; edge modes once per edge.
    case (mode)
      ACT_LEVEL_LOW: hit = on & ~level;
      ACT_LEVEL_HIGH: hit = level;
      ACT_FALL: hit = s.prev & ~level;
      ACT_RISE: hit = ~s.prev & level;
      ACT_ANY: hit = s.prev ^ level;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : dect_qual
`default_nettype wire

// ==== dv/dect_monitor.sv ====
/*
  Port-level checker of the dual event counter timer, bound to dect_top.
  Assumes one clock domain, synchronous active-high reset and the strobe register port.
*/
`timescale 1ns/1ps
`default_nettype none
module dect_monitor
  import dect_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire dect_bus_t bus,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [NUM_CNT-1:0] counter_start_evt,
  input wire logic [NUM_CNT-1:0] counter_end_evt,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic [NUM_CNT-1:0] evt_any;
  assign evt_any = counter_start_evt | counter_end_evt;

  a_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == '0)
    else $error("read data not zero outside a read answer");
  a_unmapped_read: assert property (bus.rd && bus.addr == 8'h3C |=> rdata == '0)
    else $error("unmapped read returned nonzero data");
  a_start_single: assert property ((counter_start_evt & $past(counter_start_evt)) == '0)
    else $error("start event longer than one cycle");
  a_end_single: assert property ((counter_end_evt & $past(counter_end_evt)) == '0)
    else $error("end event longer than one cycle");
  a_index_readback: assert property (bus.wr && bus.addr == REG_INDEX ##1
    bus.rd && bus.addr == REG_INDEX |=> rdata == {31'h0000_0000, $past(bus.wdata[0], 2)})
    else $error("counter index did not read back");
  a_trig_clears_clear: assert property (bus.wr && bus.addr == REG_TRIG_SRC &&
    bus.wdata[SRC_W-1:0] != '0 ##1 bus.rd && bus.addr == REG_CLEAR_SRC |=> rdata == '0)
    else $error("clear source survived a trigger selection");
  a_clear_clears_trig: assert property (bus.wr && bus.addr == REG_CLEAR_SRC &&
    bus.wdata[SRC_W-1:0] != '0 ##1 bus.rd && bus.addr == REG_TRIG_SRC |=> rdata == '0)
    else $error("trigger source survived a clear selection");
  a_mask_zero_quiet: assert property (bus.wr && bus.addr == REG_IRQ_MASK &&
    bus.wdata[IRQ_W-1:0] == '0 |=> !irq)
    else $error("interrupt high with all events masked");
  a_irq_has_cause: assert property ($rose(irq) |-> evt_any != '0 ||
    $past(bus.wr && bus.addr == REG_IRQ_MASK))
    else $error("interrupt rose without an event or mask write");
  a_state_code_range: assert property ($past(bus.rd) &&
    $past(bus.addr) == REG_STATE_REPORT |-> rdata <= 32'h0000_0004)
    else $error("status read returned an unknown state code");

  c_start_seen: cover property (counter_start_evt[0]);
  c_end_seen: cover property (counter_end_evt[0]);
  c_irq_rise: cover property ($rose(irq));
endmodule : dect_monitor

bind dect_top dect_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata),
  .counter_start_evt(counter_start_evt), .counter_end_evt(counter_end_evt), .irq(irq));
`default_nettype wire

// ==== dv/tb.sv ====
/*
  Self-checking testbench of the dual event counter timer: register tasks and pulse stimulus.
  Assumes dect_top with the default tick divider and the checker bound by its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import dect_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  dect_bus_t bus = '0;
  logic [12:0] stim = '0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_CNT-1:0] sevt;
  logic [NUM_CNT-1:0] eevt;
  logic irq;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] c1;
  int num_errors = 0;
  int checked = 0;
  int n_start = 0;
  int n_end = 0;
  logic [ACT_W-1:0] modes [4] = '{ACT_RISE, ACT_FALL, ACT_ANY, ACT_LEVEL_HIGH};
  int exps [4] = '{3, 3, 6, 3};

  dect_top i_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata),
    .line_in(stim[3:0]), .user_out(stim[7:4]), .logic_blk(stim[9:8]),
    .exposure_start(stim[10]), .exposure_end(stim[11]), .frame_trigger_wait(stim[12]),
    .counter_start_evt(sevt), .counter_end_evt(eevt), .irq(irq));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    n_start <= n_start + int'(sevt[0]);
    n_end <= n_end + int'(eevt[0]);
  end

  task automatic chk(input string name, input logic [DATA_W-1:0] seen,
      input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  // Every xfer access takes two edges so that the next one never reassigns the bus in the same step.
  task automatic xfer(input logic w, input logic r, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    bus <= '{w, r, a, d};
    @(posedge ref_clk);
    bus <= '0;
    #1 v = rdata;
    @(posedge ref_clk);
  endtask : xfer

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    xfer(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] exp);
    xfer(1'b0, 1'b1, a, '0);
    chk(name, v, exp);
  endtask : rd_chk

  task automatic wr_rd_chk(input string name, input logic [ADDR_W-1:0] wa,
      input logic [DATA_W-1:0] wd, input logic [ADDR_W-1:0] ra, input logic [DATA_W-1:0] exp);
    bus <= '{1'b1, 1'b0, wa, wd};
    @(posedge ref_clk);
    rd_chk(name, ra, exp);
  endtask : wr_rd_chk

  task automatic pls(input int b, input int n);
    repeat (n) begin
      stim[b] <= 1'b1;
      @(posedge ref_clk);
      stim[b] <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask : pls

  task automatic results;
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    results();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk("state_rst", REG_STATE_REPORT, 32'(STAT_IDLE));
    rd_chk("act_rst", REG_COUNT_ACT, 32'(ACT_RISE));
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    wr_rd_chk("index", REG_INDEX, 32'h0000_0001, REG_INDEX, 32'h0000_0001);
    wr(REG_CLEAR_SRC, 32'(SRC_LOGIC0));
    wr_rd_chk("clr_off", REG_TRIG_SRC, 32'(SRC_C0_END), REG_CLEAR_SRC, 32'h0);
    wr_rd_chk("trig_off", REG_CLEAR_SRC, 32'(SRC_LOGIC0), REG_TRIG_SRC, 32'h0);
    wr(REG_INDEX, 32'h0000_0000);
    rd_chk("c0_clear", REG_CLEAR_SRC, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(REG_COUNT_SRC, 32'(SRC_OFF));
      wr(REG_COUNT_ACT, 32'(modes[i]));
      wr(REG_COUNT_SRC, 32'(SRC_USER0));
      pls(4, 3);
      rd_chk("mode_count", REG_PRESENT_COUNT, 32'(exps[i]));
    end
    // Source held low, so the count must grow by one on every cycle between two reads.
    wr(REG_COUNT_ACT, 32'(ACT_LEVEL_LOW));
    xfer(1'b0, 1'b1, REG_PRESENT_COUNT, '0);
    c1 = v;
    xfer(1'b0, 1'b1, REG_PRESENT_COUNT, '0);
    chk("level_low", v - c1, 32'h0000_0002);
    wr(REG_COUNT_SRC, 32'(SRC_OFF));
    wr(REG_COUNT_ACT, 32'(ACT_RISE));
    wr(REG_START_DELAY, 32'h0000_0002);
    wr(REG_END_DURATION, 32'h0000_0004);
    wr(REG_IRQ_MASK, 32'h0000_000F);
    wr(REG_COUNT_SRC, 32'(SRC_USER0));
    pls(4, 6);
    chk("starts", 32'(n_start), 32'h0000_0001);
    chk("ends", 32'(n_end), 32'h0000_0001);
    rd_chk("end_count", REG_PRESENT_COUNT, 32'h0000_0004);
    rd_chk("done", REG_STATE_REPORT, 32'(STAT_COMPLETED));
    chk("irq_on", 32'(irq), 32'h0000_0001);
    rd_chk("irq_stat", REG_IRQ_STATUS, 32'h0000_0003);
    rd_chk("irq_clr", REG_IRQ_STATUS, 32'h0000_0000);
    chk("irq_off", 32'(irq), 32'h0000_0000);
    wr(REG_CLEAR_SRC, 32'(SRC_LOGIC0));
    wr(REG_CLEAR_ACT, 32'(ACT_FALL));
    pls(8, 1);
    rd_chk("captured", REG_CAPTURED, 32'h0000_0004);
    pls(4, 1);
    rd_chk("after_clr", REG_PRESENT_COUNT, 32'h0000_0001);
    rd_chk("clr_state", REG_STATE_REPORT, 32'(STAT_ACTIVE));
    wr(REG_INDEX, 32'h0000_0001);
    wr(REG_TRIG_SRC, 32'(SRC_EXP_START));
    wr(REG_TRIG_ACT, 32'(ACT_FALL));
    wr(REG_COUNT_SRC, 32'(SRC_USER0));
    rd_chk("trig_wait", REG_STATE_REPORT, 32'(STAT_TRIG_WAIT));
    pls(4, 2);
    rd_chk("no_trig", REG_PRESENT_COUNT, 32'h0000_0000);
    pls(10, 1);
    pls(4, 3);
    rd_chk("trig_cnt", REG_PRESENT_COUNT, 32'h0000_0003);
    wr(REG_COUNT_SRC, 32'(SRC_OFF));
    wr(REG_TRIG_SRC, 32'(SRC_OFF));
    wr(REG_COUNT_ACT, 32'(ACT_LEVEL_HIGH));
    wr(REG_COUNT_SRC, 32'(SRC_TICK));
    xfer(1'b0, 1'b1, REG_PRESENT_COUNT, '0);
    c1 = v;
    repeat (998) @(posedge ref_clk);
    xfer(1'b0, 1'b1, REG_PRESENT_COUNT, '0);
    chk("ticks", v - c1, 32'(1000 / TICK_CYCLES));
    wr(REG_COUNT_SRC, 32'(SRC_OFF));
    wr(REG_COUNT_ACT, 32'(ACT_ANY));
    wr(REG_COUNT_SRC, 32'(SRC_EXP_END));
    pls(11, 2);
    rd_chk("exp_end", REG_PRESENT_COUNT, 32'h0000_0004);
    wr(REG_COUNT_SRC, 32'(SRC_OFF));
    wr(REG_COUNT_SRC, 32'(SRC_FRAME_WAIT));
    pls(12, 3);
    rd_chk("frame_wait", REG_PRESENT_COUNT, 32'h0000_0006);
    wr(REG_COUNT_SRC, 32'(SRC_COUNT));
    rd_chk("bad_src", REG_STATE_REPORT, 32'(STAT_IDLE));
    wr(REG_IRQ_MASK, 32'h0000_0000);
    rd_chk("unmapped2", 8'h38, 32'h0000_0000);
    chk("irq_masked", 32'(irq), 32'h0000_0000);
    results();
  end
endmodule : tb
`default_nettype wire
